//--- hw/timer_pkg.sv
// Shared offsets, field positions and reset values of one timer channel
package timer_pkg;

  // Register offsets on the plain register port
  localparam logic [3:0] OFS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_IO_FUNC = 4'h1;
  localparam logic [3:0] OFS_IRQ_EN = 4'h2;
  localparam logic [3:0] OFS_FLAGS = 4'h3;
  localparam logic [3:0] OFS_COUNT = 4'h4;
  localparam logic [3:0] OFS_GR_FIRST = 4'h5;
  localparam logic [3:0] OFS_GR_SECOND = 4'h6;
  localparam logic [3:0] OFS_MODE = 4'h7;

  // Flag and enable bit positions
  localparam int OVERFLOW_BIT = 2;
  localparam int SECOND_MATCH_BIT = 1;
  localparam int FIRST_MATCH_BIT = 0;
  localparam logic [7:0] FLAG_RESERVED_ONES = 8'hF8;

  // Control register layout
  localparam int CLEAR_LSB = 5;
  localparam int CLOCK_SEL_LSB = 0;
  localparam logic [7:0] CONTROL_RESERVED_ONES = 8'h98;

  // I/O function register layout
  localparam int IO_SECOND_LSB = 4;
  localparam int IO_FIRST_LSB = 0;
  localparam logic [7:0] IO_RESERVED_ONES = 8'h88;

  // Mode register layout
  localparam int START_BIT = 0;
  localparam int PWM_BIT = 1;

  // Reset values
  localparam logic [2:0] FUNC_RESET = 3'h0;
  localparam logic [2:0] CLOCK_SEL_RESET = 3'h0;
  localparam logic [2:0] IRQ_EN_RESET = 3'h0;
  localparam logic [2:0] FLAGS_RESET = 3'h0;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] GR_RESET = 16'hFFFF;

  // General register functions
  localparam logic [2:0] IO_COMPARE_QUIET = 3'h0;
  localparam logic [2:0] IO_DRIVE_LOW = 3'h1;
  localparam logic [2:0] IO_DRIVE_HIGH = 3'h2;
  localparam logic [2:0] IO_TOGGLE = 3'h3;
  localparam logic [2:0] IO_CAPTURE_RISE = 3'h4;
  localparam logic [2:0] IO_CAPTURE_FALL = 3'h5;
  localparam logic [2:0] IO_CAPTURE_BOTH = 3'h6;

  // Counter clear sources, in field code order 00..11
  typedef enum logic [1:0] {CLR_FREE, CLR_FIRST, CLR_SECOND, CLR_SYNC} clear_src_t;

endpackage

//--- hw/timer_prescaler.sv
// Count-enable source: bus clock divider and external clock edges
`timescale 1ns/100ps
module timer_prescaler (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Selection
  input wire logic [2:0] clock_select_field,
  input wire logic [3:0] ext_clk,
  // Enable pulse
  output logic tick
);

  logic [5:0] div_reg;
  logic [3:0] ext_reg;
  logic tick_next;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      div_reg <= 6'h00;
    else
      div_reg <= div_reg + 6'h01;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      ext_reg <= 4'h0;
    else
      ext_reg <= ext_clk;
  end

  // External clocks count on their rising edge
  always_comb
  begin
    unique case (clock_select_field)
      3'h0: tick_next = div_reg[0];
      3'h1: tick_next = &div_reg[1:0];
      3'h2: tick_next = &div_reg[3:0];
      3'h3: tick_next = &div_reg;
      default: tick_next = ext_clk[clock_select_field[1:0]] & ~ext_reg[clock_select_field[1:0]];
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      tick <= 1'b0;
    else
      tick <= tick_next;
  end

endmodule

//--- hw/timer_compare_unit.sv
// One general register with its compare match and input capture logic
`timescale 1ns/100ps
module timer_compare_unit #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Software side
  input wire logic [2:0] func,
  input wire logic wr_en,
  input wire logic [W-1:0] wr_data,
  output logic [W-1:0] gr_value,
  // Counter side
  input wire logic [W-1:0] count,
  input wire logic tick,
  output logic event_pulse,
  // Pin
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe
);

  logic pin_reg;
  logic is_compare;
  logic match;
  logic capture;

  assign is_compare = (func <= timer_pkg::IO_TOGGLE);
  assign match = is_compare & tick & (count == gr_value);

  always_comb
  begin
    unique case (func)
      timer_pkg::IO_CAPTURE_RISE: capture = pin_in & ~pin_reg;
      timer_pkg::IO_CAPTURE_FALL: capture = ~pin_in & pin_reg;
      timer_pkg::IO_CAPTURE_BOTH: capture = pin_in ^ pin_reg;
      default: capture = 1'b0;
    endcase
  end

  assign event_pulse = match | capture;
  assign pin_oe = is_compare & (func != timer_pkg::IO_COMPARE_QUIET);

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      pin_reg <= 1'b0;
    else
      pin_reg <= pin_in;
  end

  // Capture beats a software write in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      gr_value <= timer_pkg::GR_RESET;
    else if (capture)
      gr_value <= count;
    else if (wr_en)
      gr_value <= wr_data;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      pin_out <= 1'b0;
    else if (match)
    begin
      unique case (func)
        timer_pkg::IO_DRIVE_LOW: pin_out <= 1'b0;
        timer_pkg::IO_DRIVE_HIGH: pin_out <= 1'b1;
        timer_pkg::IO_TOGGLE: pin_out <= ~pin_out;
        default: pin_out <= pin_out;
      endcase
    end
  end

endmodule

//--- hw/timer_channel.sv
// One 16-bit timer channel: counter, two general registers, flags, enables
// Functional notes
// - Channel owns an 8-bit read/write interrupt enable register gating its requests.
// - Enable bit 2 overflow, bit 1 second match, bit 0 first match; reset 0.
// - Request is raised while a flag is set and its enable is 1.
// - Flag bit 2 sets on counter overflow; reads 0 after reset.
// - Flag bit 1 sets on second register match or capture; resets 0.
// - Flag bit 0 sets on first register match or capture; resets 0.
// - Flag register is 8 bits, readable, 1 in set condition, 0 otherwise.
// - Counter is a 16-bit up-counter, readable and writable at any time.
// - Counter advances on the clock source chosen in its control register.
// - Clear source set to a register match or capture zeroes a started counter then.
// - Two 16-bit read/write general registers per channel.
// - Each general register is compare or capture as its function field says.
// - PWM with period from first register gives true 0% and 100% duty.
// - Clear field: 00 free, 01 first, 10 second, 11 synchronized clear.
// - Clock field: bus clock /2,/4,/16,/64, then external clocks 1 to 4.
// - Function field: quiet, drive 0, drive 1, toggle, capture rise, fall, both.
//
// The address-and-strobe port and the register addresses were decided locally.
`timescale 1ns/100ps
module timer_channel #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // External count clocks
  input wire logic [3:0] ext_clk,
  // Synchronized clearing with other channels
  input wire logic sync_clear_in,
  output logic clear_event_out,
  // First register pin
  input wire logic pin_a_line_in,
  output logic pin_a_line_out,
  output logic pin_a_line_oe,
  // Second register pin
  input wire logic pin_b_line_in,
  output logic pin_b_line_out,
  output logic pin_b_line_oe,
  // Interrupt requests
  output logic irq_overflow,
  output logic irq_second_match,
  output logic irq_first_match
);

  // Software-visible state
  timer_pkg::clear_src_t clear_source_field;
  logic [2:0] clock_select_field;
  logic [2:0] first_func_reg;
  logic [2:0] second_func_reg;
  logic [2:0] irq_enable_reg;
  logic [2:0] event_flag_reg;
  logic [2:0] event_flag_next;
  logic [W-1:0] channel_counter;
  logic [W-1:0] channel_counter_next;
  logic start_bit;
  logic pwm_mode;
  logic pwm_level_reg;

  // Internal strobes
  logic wr_control;
  logic wr_io;
  logic wr_irq_en;
  logic wr_flags;
  logic wr_count;
  logic wr_first;
  logic wr_second;
  logic wr_mode;
  logic tick;
  logic count_tick;
  logic first_event;
  logic second_event;
  logic clear_now;
  logic overflow;
  logic [2:0] flag_set;
  logic [2:0] flag_clr;
  logic [W-1:0] first_value;
  logic [W-1:0] second_value;
  logic first_pin_out;
  logic first_pin_oe;
  logic [15:0] read_mux;

  // Address decode
  assign wr_control = reg_wr & (reg_addr == timer_pkg::OFS_CONTROL);
  assign wr_io = reg_wr & (reg_addr == timer_pkg::OFS_IO_FUNC);
  assign wr_irq_en = reg_wr & (reg_addr == timer_pkg::OFS_IRQ_EN);
  assign wr_flags = reg_wr & (reg_addr == timer_pkg::OFS_FLAGS);
  assign wr_count = reg_wr & (reg_addr == timer_pkg::OFS_COUNT);
  assign wr_first = reg_wr & (reg_addr == timer_pkg::OFS_GR_FIRST);
  assign wr_second = reg_wr & (reg_addr == timer_pkg::OFS_GR_SECOND);
  assign wr_mode = reg_wr & (reg_addr == timer_pkg::OFS_MODE);

  // Count enable source
  timer_prescaler u_prescaler (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clock_select_field(clock_select_field),
    .ext_clk(ext_clk),
    .tick(tick)
  );

  // Stopped counter sees no ticks, so no compare match either
  assign count_tick = tick & start_bit;

  // General registers
  timer_compare_unit #(
    .W(W)
  ) u_first (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .func(first_func_reg),
    .wr_en(wr_first),
    .wr_data(reg_wdata[W-1:0]),
    .gr_value(first_value),
    .count(channel_counter),
    .tick(count_tick),
    .event_pulse(first_event),
    .pin_in(pin_a_line_in),
    .pin_out(first_pin_out),
    .pin_oe(first_pin_oe)
  );

  timer_compare_unit #(
    .W(W)
  ) u_second (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .func(second_func_reg),
    .wr_en(wr_second),
    .wr_data(reg_wdata[W-1:0]),
    .gr_value(second_value),
    .count(channel_counter),
    .tick(count_tick),
    .event_pulse(second_event),
    .pin_in(pin_b_line_in),
    .pin_out(pin_b_line_out),
    .pin_oe(pin_b_line_oe)
  );

  // Clear source selection
  always_comb
  begin
    unique case (clear_source_field)
      timer_pkg::CLR_FREE: clear_now = 1'b0;
      timer_pkg::CLR_FIRST: clear_now = first_event;
      timer_pkg::CLR_SECOND: clear_now = second_event;
      timer_pkg::CLR_SYNC: clear_now = sync_clear_in;
    endcase
  end

  assign clear_event_out = clear_now & start_bit;

  // Wrap from all ones, unless the same tick clears the counter
  assign overflow = count_tick & (&channel_counter) & ~clear_now;

  // Software write wins over clear, clear over counting
  always_comb
  begin
    channel_counter_next = channel_counter;
    if (wr_count)
      channel_counter_next = reg_wdata[W-1:0];
    else if (clear_now & start_bit)
      channel_counter_next = '0;
    else if (count_tick)
      channel_counter_next = channel_counter + 1'b1;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      channel_counter <= timer_pkg::COUNT_RESET;
    else
      channel_counter <= channel_counter_next;
  end

  // Flag update: a new event beats a clearing write
  assign flag_set[timer_pkg::OVERFLOW_BIT] = overflow;
  assign flag_set[timer_pkg::SECOND_MATCH_BIT] = second_event;
  assign flag_set[timer_pkg::FIRST_MATCH_BIT] = first_event;
  assign flag_clr = wr_flags ? ~reg_wdata[2:0] : 3'h0;
  assign event_flag_next = (event_flag_reg & ~flag_clr) | flag_set;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      event_flag_reg <= timer_pkg::FLAGS_RESET;
    else
      event_flag_reg <= event_flag_next;
  end

  // Interrupt enable register
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      irq_enable_reg <= timer_pkg::IRQ_EN_RESET;
    else if (wr_irq_en)
      irq_enable_reg <= reg_wdata[2:0];
  end

  // Requests gated by enables
  assign irq_overflow = event_flag_reg[timer_pkg::OVERFLOW_BIT] &
    irq_enable_reg[timer_pkg::OVERFLOW_BIT];
  assign irq_second_match = event_flag_reg[timer_pkg::SECOND_MATCH_BIT] &
    irq_enable_reg[timer_pkg::SECOND_MATCH_BIT];
  assign irq_first_match = event_flag_reg[timer_pkg::FIRST_MATCH_BIT] &
    irq_enable_reg[timer_pkg::FIRST_MATCH_BIT];

  // Control register
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clear_source_field <= timer_pkg::CLR_FREE;
      clock_select_field <= timer_pkg::CLOCK_SEL_RESET;
    end
    else if (wr_control)
    begin
      clear_source_field <= timer_pkg::clear_src_t'(reg_wdata[timer_pkg::CLEAR_LSB +: 2]);
      clock_select_field <= reg_wdata[timer_pkg::CLOCK_SEL_LSB +: 3];
    end
  end

  // I/O function register
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      first_func_reg <= timer_pkg::FUNC_RESET;
      second_func_reg <= timer_pkg::FUNC_RESET;
    end
    else if (wr_io)
    begin
      first_func_reg <= reg_wdata[timer_pkg::IO_FIRST_LSB +: 3];
      second_func_reg <= reg_wdata[timer_pkg::IO_SECOND_LSB +: 3];
    end
  end

  // Start and PWM mode bits
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      start_bit <= 1'b0;
      pwm_mode <= 1'b0;
    end
    else if (wr_mode)
    begin
      start_bit <= reg_wdata[timer_pkg::START_BIT];
      pwm_mode <= reg_wdata[timer_pkg::PWM_BIT];
    end
  end

  // PWM level: high while count below second register.
  // Zero there gives 0%, above the period gives 100%.
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      pwm_level_reg <= 1'b0;
    else
      pwm_level_reg <= (channel_counter_next < second_value);
  end

  assign pin_a_line_out = pwm_mode ? pwm_level_reg : first_pin_out;
  assign pin_a_line_oe = pwm_mode | first_pin_oe;

  // Read multiplexer
  always_comb
  begin
    read_mux = 16'h0000;
    unique case (reg_addr)
      timer_pkg::OFS_CONTROL:
        read_mux[7:0] = timer_pkg::CONTROL_RESERVED_ONES |
          {1'b0, clear_source_field, 2'b00, clock_select_field};
      timer_pkg::OFS_IO_FUNC:
        read_mux[7:0] = timer_pkg::IO_RESERVED_ONES |
          {1'b0, second_func_reg, 1'b0, first_func_reg};
      timer_pkg::OFS_IRQ_EN:
        read_mux[7:0] = timer_pkg::FLAG_RESERVED_ONES | {5'h00, irq_enable_reg};
      timer_pkg::OFS_FLAGS:
        read_mux[7:0] = timer_pkg::FLAG_RESERVED_ONES | {5'h00, event_flag_reg};
      timer_pkg::OFS_COUNT:
        read_mux = channel_counter;
      timer_pkg::OFS_GR_FIRST:
        read_mux = first_value;
      timer_pkg::OFS_GR_SECOND:
        read_mux = second_value;
      timer_pkg::OFS_MODE:
        read_mux[1:0] = {pwm_mode, start_bit};
      default:
        read_mux = 16'h0000;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
      reg_rdata <= read_mux;
    else
      reg_rdata <= 16'h0000;
  end

endmodule

//--- tb/pin_partner.sv
// Far side model: capture pin stimulus, compare pin sense, external clocks
`timescale 1ns/100ps
module pin_partner (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Bench commands
  input wire logic [3:0] ext_run,
  input wire logic edge_b,
  // Pins
  input wire logic pin_a_line_out,
  input wire logic pin_a_line_oe,
  output logic pin_a_line_in,
  output logic pin_b_line_in,
  output logic [3:0] ext_clk
);
  // Pull-down: an undriven line reads low
  assign pin_a_line_in = pin_a_line_oe & pin_a_line_out;

  // Only commanded clocks move; idle ones stay low
  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      ext_clk <= 4'h0;
    else
      ext_clk <= (ext_clk ^ ext_run) & ext_run;

  always_ff @(posedge sys_clk or negedge rst_n)
    if (!rst_n)
      pin_b_line_in <= 1'b0;
    else
      pin_b_line_in <= edge_b;
endmodule

//--- tb/timer_channel_asserts.sv
// Port-level checker for one timer channel
`timescale 1ns/100ps
module timer_channel_checker (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic pin_b_line_oe,
  input wire logic irq_overflow,
  input wire logic irq_second_match,
  input wire logic irq_first_match
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_read_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside its cycle");
  a_enable_read_back: assert property (($past(reg_wr, 2) && $past(reg_rd)
    && $past(reg_addr, 2) == timer_pkg::OFS_IRQ_EN && $past(reg_addr) == timer_pkg::OFS_IRQ_EN)
    |-> reg_rdata == (($past(reg_wdata, 2) & 16'h0007) | 16'h00F8))
    else $error("enable register read back wrong");
  a_flag_reserved_ones: assert property (($past(reg_rd) && $past(reg_addr) == timer_pkg::OFS_FLAGS)
    |-> reg_rdata[15:3] == 13'h001F)
    else $error("flag register reserved bits wrong");
  a_unmapped_reads_zero: assert property (($past(reg_rd) && $past(reg_addr) >= 4'h8)
    |-> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_general_read_back: assert property (($past(reg_wr, 2) && $past(reg_rd)
    && $past(reg_addr, 2) == timer_pkg::OFS_GR_FIRST
    && $past(reg_addr) == timer_pkg::OFS_GR_FIRST) |-> reg_rdata == $past(reg_wdata, 2))
    else $error("general register read back wrong");
  a_first_irq_held: assert property (irq_first_match && !reg_wr |=> irq_first_match)
    else $error("first match request dropped without write");
  a_second_irq_held: assert property (irq_second_match && !reg_wr |=> irq_second_match)
    else $error("second match request dropped without write");
  a_ovf_irq_held: assert property (irq_overflow && !reg_wr |=> irq_overflow)
    else $error("overflow request dropped without write");
  a_pin_oe_steady: assert property (!$past(reg_wr) |-> $stable(pin_b_line_oe))
    else $error("pin enable moved without register write");

  c_overflow: cover property (irq_overflow);
  c_first: cover property (irq_first_match);
  c_second: cover property (irq_second_match);
endmodule

bind timer_channel timer_channel_checker timer_channel_checker_i (
  .sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_b_line_oe(pin_b_line_oe),
  .irq_overflow(irq_overflow), .irq_second_match(irq_second_match),
  .irq_first_match(irq_first_match)
);

//--- tb/tb.sv
// Self-checking bench for one timer channel
`timescale 1ns/100ps
module tb;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic sync_clear_in = 1'b0;
  logic [3:0] ext_run = 4'h0;
  logic edge_b = 1'b0;
  logic [15:0] reg_rdata, rdv;
  logic [3:0] ext_clk;
  logic pin_a_line_in, pin_a_line_out, pin_a_line_oe;
  logic pin_b_line_in, pin_b_line_out, pin_b_line_oe;
  logic clear_event_out, irq_overflow, irq_second_match, irq_first_match;
  int mismatches = 0;
  int checks = 0;
  int n;
  int div[8] = '{2, 4, 16, 64, 2, 2, 2, 2};
  int lo[4] = '{6, 0, 0, 0};
  int hi[4] = '{100, 3, 5, 0};
  logic [15:0] fexp[4] = '{16'h00FB, 16'h00F9, 16'h00FB, 16'h00F8};

  always #50 sys_clk = ~sys_clk;

  timer_channel timer_channel_i (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_clk(ext_clk), .sync_clear_in(sync_clear_in), .clear_event_out(clear_event_out),
    .pin_a_line_in(pin_a_line_in), .pin_a_line_out(pin_a_line_out),
    .pin_a_line_oe(pin_a_line_oe), .pin_b_line_in(pin_b_line_in),
    .pin_b_line_out(pin_b_line_out), .pin_b_line_oe(pin_b_line_oe),
    .irq_overflow(irq_overflow), .irq_second_match(irq_second_match),
    .irq_first_match(irq_first_match));

  pin_partner pin_partner_i (.sys_clk(sys_clk), .rst_n(rst_n), .ext_run(ext_run),
    .edge_b(edge_b), .pin_a_line_out(pin_a_line_out), .pin_a_line_oe(pin_a_line_oe),
    .pin_a_line_in(pin_a_line_in), .pin_b_line_in(pin_b_line_in), .ext_clk(ext_clk));

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // A write directly after a write waits one edge so the strobe is driven once per step
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    if (reg_wr)
      @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe, so take it mid-cycle
  task automatic rd(input logic [3:0] a);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    rdv = reg_rdata;
    @(posedge sys_clk);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    #2000000;
    mismatches++;
    finish_test();
  end

  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(timer_pkg::OFS_IRQ_EN);
    chk("enable reset", 16'h00F8, rdv);
    rd(timer_pkg::OFS_FLAGS);
    chk("flags reset", 16'h00F8, rdv);
    rd(timer_pkg::OFS_COUNT);
    chk("count reset", 16'h0000, rdv);
    rd(4'hC);
    chk("unmapped", 16'h0000, rdv);
    wr(timer_pkg::OFS_IRQ_EN, 16'hFF05);
    rd(timer_pkg::OFS_IRQ_EN);
    chk("enable rw", 16'h00FD, rdv);
    wr(timer_pkg::OFS_FLAGS, 16'h0000);
    rd(timer_pkg::OFS_FLAGS);
    chk("flags write", 16'h00F8, rdv);
    wr(timer_pkg::OFS_GR_FIRST, 16'hA5C3);
    rd(timer_pkg::OFS_GR_FIRST);
    chk("first gr", 16'hA5C3, rdv);
    wr(timer_pkg::OFS_GR_SECOND, 16'h5A3C);
    rd(timer_pkg::OFS_GR_SECOND);
    chk("second gr", 16'h5A3C, rdv);
    wr(timer_pkg::OFS_COUNT, 16'h1234);
    repeat (20) @(posedge sys_clk);
    rd(timer_pkg::OFS_COUNT);
    chk("stopped count", 16'h1234, rdv);
    wr(timer_pkg::OFS_IRQ_EN, 16'h0004);
    for (int c = 0; c < 8; c++)
    begin
      ext_run <= (c > 3) ? (4'h1 << (c - 4)) : 4'h0;
      wr(timer_pkg::OFS_CONTROL, 16'(c));
      wr(timer_pkg::OFS_COUNT, 16'hFFFE);
      wr(timer_pkg::OFS_MODE, 16'h0001);
      n = 0;
      while (irq_overflow !== 1'b1 && n < 300)
      begin
        @(negedge sys_clk);
        n++;
      end
      @(posedge sys_clk);
      chk("tick rate", 16'h0001, {15'h0, n >= div[c] && n <= 2 * div[c] + 3});
      wr(timer_pkg::OFS_MODE, 16'h0000);
      rd(timer_pkg::OFS_FLAGS);
      chk("overflow flag", 16'h00FC, rdv);
      wr(timer_pkg::OFS_FLAGS, 16'h00FB);
      rd(timer_pkg::OFS_FLAGS);
      chk("overflow clear", 16'h00F8, rdv);
    end
    ext_run <= 4'h0;
    wr(timer_pkg::OFS_IRQ_EN, 16'h0001);
    wr(timer_pkg::OFS_GR_FIRST, 16'h0003);
    wr(timer_pkg::OFS_GR_SECOND, 16'h0005);
    for (int k = 0; k < 4; k++)
    begin
      sync_clear_in <= (k == 3);
      wr(timer_pkg::OFS_CONTROL, 16'(k << 5));
      wr(timer_pkg::OFS_FLAGS, 16'h0000);
      wr(timer_pkg::OFS_COUNT, 16'h0000);
      wr(timer_pkg::OFS_MODE, 16'h0001);
      repeat (40) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("first irq", {15'h0, fexp[k][0]}, {15'h0, irq_first_match});
      chk("second irq masked", 16'h0000, {15'h0, irq_second_match});
      // Match-cleared modes pulse briefly, so only the steady cases are looked at
      if (k == 0 || k == 3)
        chk("clear out", 16'(k == 3), {15'h0, clear_event_out});
      @(posedge sys_clk);
      wr(timer_pkg::OFS_MODE, 16'h0000);
      rd(timer_pkg::OFS_COUNT);
      chk("clear bound", 16'h0001, {15'h0, rdv >= lo[k] && rdv <= hi[k]});
      rd(timer_pkg::OFS_FLAGS);
      chk("match flags", fexp[k], rdv);
    end
    sync_clear_in <= 1'b0;
    wr(timer_pkg::OFS_IO_FUNC, 16'h0040);
    rd(timer_pkg::OFS_IO_FUNC);
    chk("io field", 16'h00C8, rdv);
    wr(timer_pkg::OFS_COUNT, 16'h0100);
    wr(timer_pkg::OFS_FLAGS, 16'h0000);
    wr(timer_pkg::OFS_IRQ_EN, 16'h0002);
    edge_b <= 1'b1;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("capture irq", 16'h0001, {15'h0, irq_second_match});
    @(posedge sys_clk);
    rd(timer_pkg::OFS_GR_SECOND);
    chk("captured value", 16'h0100, rdv);
    edge_b <= 1'b0;
    for (int f = 0; f < 7; f++)
    begin
      wr(timer_pkg::OFS_IO_FUNC, 16'(f << 4));
      @(negedge sys_clk);
      chk("pin drive", {15'h0, f >= 1 && f <= 3}, {15'h0, pin_b_line_oe});
      @(posedge sys_clk);
    end
    // Drive high, then drive low, on a match at the captured value
    for (int d = 2; d > 0; d--)
    begin
      wr(timer_pkg::OFS_IO_FUNC, 16'(d << 4));
      wr(timer_pkg::OFS_COUNT, 16'h00FE);
      wr(timer_pkg::OFS_MODE, 16'h0001);
      repeat (10) @(posedge sys_clk);
      @(negedge sys_clk);
      chk("pin level", 16'(d == 2), {15'h0, pin_b_line_out});
      @(posedge sys_clk);
      wr(timer_pkg::OFS_MODE, 16'h0000);
    end
    wr(timer_pkg::OFS_IO_FUNC, 16'h0000);
    wr(timer_pkg::OFS_CONTROL, 16'h0020);
    for (int p = 0; p < 2; p++)
    begin
      wr(timer_pkg::OFS_GR_SECOND, p ? 16'h0005 : 16'h0000);
      wr(timer_pkg::OFS_COUNT, 16'h0000);
      wr(timer_pkg::OFS_MODE, 16'h0003);
      repeat (6) @(posedge sys_clk);
      for (n = 0; n < 16; n++)
      begin
        @(negedge sys_clk);
        chk("pwm level", 16'(p), {15'h0, pin_a_line_out});
      end
      chk("pwm enable", 16'h0001, {15'h0, pin_a_line_oe});
      @(posedge sys_clk);
      wr(timer_pkg::OFS_MODE, 16'h0000);
    end
    finish_test();
  end
endmodule
